// ==== rtl/bds_pkg.sv ====
// Purpose: shared constants and types for the buffer DRAM timing sequencer
// Assumes: system clock period T equals the sequencer clock (100 MHz)
// Notes: all pin intervals are whole clock counts derived from T figures
// Operation
// - random read or write cycle, RAS fall to RAS fall, lasts at least 10T
// - page mode column accesses are spaced at least 4T apart
// - CAS asserts at least 2T after RAS asserts
// - row address is on the bus at least 3T-10ns before RAS falls
// - column address stays stable at least 5T-10ns after RAS falls
// - column address is presented at least 3T before RAS rises
// - in page mode RAS stays low at least 4T after final CAS precharge
// - at least 3T-10ns from CAS rising to next RAS falling
// - read level on write command at least 4T-10ns before CAS falls
// - read level held at least 2T-10ns after RAS rises
// - write command held low at least 10T during a write
// - write command held at least 6T-10ns after CAS falls
// - write command held at least 8T-10ns from RAS falling
// - write command asserted at least 9T-10ns before CAS rises
// - write command asserted at least 8T-10ns before RAS rises
// - write data driven at least 3T after CAS falls
// - write data driven at least 7T-10ns after RAS falls
// - refresh: CAS falls at least 2T-10ns before RAS falls
// - refresh: CAS held at least 6T-10ns after RAS falls

package bds_pkg;

    localparam int CLK_NS = 10;   // sequencer clock period
    localparam int T_NS = 10;     // device system clock period T

    // least time rounds up, never below one cycle
    function automatic int cycMin(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time rounds down, never below one cycle
    function automatic int cycMax(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // intervals in units of T; where a rule allows 10 ns less, that allowance is not taken, so those hold with margin
    localparam int ASR_T = 3;     // row address set-up before RAS
    localparam int RAH_T = 1;     // row address hold after RAS
    localparam int RCD_T = 2;     // RAS to CAS delay
    localparam int RAC_T = 7;     // access from RAS
    localparam int CAC_T = 3;     // access from CAS
    localparam int CP_T = 1;      // CAS high pulse in page mode
    localparam int RHCP_T = 4;    // RAS hold after CAS precharge
    localparam int RP_T = 4;      // RAS high time
    localparam int WP_T = 10;     // write command low time
    localparam int CSR_T = 2;     // CAS set-up for refresh
    localparam int CHR_T = 6;     // CAS hold for refresh
    localparam int RFSH_SHORT_T = 400;
    localparam int RFSH_LONG_T = 800;

    localparam int ASR_CYC = cycMin(ASR_T * T_NS);
    localparam int RAH_CYC = cycMin(RAH_T * T_NS);
    localparam int RCD_CYC = cycMin(RCD_T * T_NS);
    localparam int RCAS_CYC = cycMin((RAC_T - RCD_T) * T_NS);
    localparam int CAC_CYC = cycMin(CAC_T * T_NS);
    localparam int CP_CYC = cycMin(CP_T * T_NS);
    localparam int RHCP_CYC = cycMin(RHCP_T * T_NS);
    localparam int RP_CYC = cycMin(RP_T * T_NS);
    localparam int WCAS_CYC = cycMin((WP_T - RCD_T) * T_NS);
    localparam int CSR_CYC = cycMin(CSR_T * T_NS);
    localparam int CHR_CYC = cycMin(CHR_T * T_NS);
    localparam int RFSH_SHORT_CYC = cycMax(RFSH_SHORT_T * T_NS);
    localparam int RFSH_LONG_CYC = cycMax(RFSH_LONG_T * T_NS);
    localparam int RFSH_GUARD_CYC = 32;   // covers the longest access still in flight

    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int CNT_W = 5;
    localparam int REF_W = 10;
    localparam int SYNC_DEPTH = 2;

    typedef struct packed {
        logic write;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } bds_req_t;

    typedef struct packed {
        logic rasN;
        logic casN;
        logic weN;
        logic [ADDR_W-1:0] addr;
        logic dqOe;
        logic [DATA_W-1:0] dqOut;
    } bds_pins_t;

    localparam bds_pins_t PINS_REST = '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, addr: 9'h000,
                                        dqOe: 1'b0, dqOut: 8'h00};

endpackage

// ==== rtl/bds_read_capture.sv ====
// Purpose: synchronise DRAM read data and capture it on the sample strobe
// Assumes: dqIn is an asynchronous pin, strobe marks the last CAS-low cycle
// Notes: strobe is delayed to match the two-flop data synchroniser
`timescale 1ns/1ps
`default_nettype none
module bds_read_capture (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [bds_pkg::DATA_W-1:0] dqIn,
    input wire logic sampleStrobe,
    output logic rdValid,
    output logic [bds_pkg::DATA_W-1:0] rdData
);
    import bds_pkg::*;

    logic [DATA_W-1:0] syncMeta;
    logic [DATA_W-1:0] syncData;
    logic [SYNC_DEPTH-1:0] strobeDly;

    // two flops per data bit; the first is read only by the second
    genvar b;
    generate
        for (b = 0; b < DATA_W; b++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                syncMeta[b] <= dqIn[b];
                syncData[b] <= syncMeta[b];
            end
        end
    endgenerate

    // strobe pipeline matches the synchroniser depth
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strobeDly <= '0;
        end else begin
            strobeDly <= {strobeDly[SYNC_DEPTH-2:0], sampleStrobe};
        end
    end

    // one-cycle valid pulse with the captured byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdValid <= 1'b0;
            rdData <= '0;
        end else begin
            rdValid <= strobeDly[SYNC_DEPTH-1];
            if (strobeDly[SYNC_DEPTH-1]) begin
                rdData <= syncData;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/bds_refresh_timer.sv ====
// Purpose: refresh interval timer for the buffer DRAM
// Assumes: memory_config_bit3 comes from logic on sys_clk
// Notes: due is raised a guard early so any running access can finish first
`timescale 1ns/1ps
`default_nettype none
module bds_refresh_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic memory_config_bit3,
    input wire logic refreshStart,
    output logic refreshDue
);
    import bds_pkg::*;

    localparam logic [REF_W-1:0] SHORT_DUE = REF_W'(RFSH_SHORT_CYC - RFSH_GUARD_CYC);
    localparam logic [REF_W-1:0] LONG_DUE = REF_W'(RFSH_LONG_CYC - RFSH_GUARD_CYC);

    logic [REF_W-1:0] count;
    logic [REF_W-1:0] dueAt;

    assign dueAt = memory_config_bit3 ? LONG_DUE : SHORT_DUE;

    // cycles since the last refresh start (final CAS set-up cycle, before RAS falls), saturating at the due point
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
        end else if (refreshStart) begin
            count <= '0;
        end else if (count < dueAt) begin
            count <= count + 1'b1;
        end
    end

    // refresh request stays up until the refresh cycle starts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            refreshDue <= 1'b0;
        end else begin
            refreshDue <= !refreshStart && (count >= dueAt);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/bds_sequencer.sv ====
// Purpose: buffer DRAM timing sequencer: random, page-mode and CBR refresh cycles
// Assumes: one clock at T, synchronous active-high reset
// Notes: pins are registered, so they follow the state by one cycle
`timescale 1ns/1ps
`default_nettype none
module bds_sequencer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic memory_config_bit3,
    input wire logic pageEnable,
    input wire logic reqValid,
    output logic reqReady,
    input wire bds_pkg::bds_req_t req,
    output logic rdValid,
    output logic [bds_pkg::DATA_W-1:0] rdData,
    output bds_pkg::bds_pins_t dramPins,
    input wire logic [bds_pkg::DATA_W-1:0] dqIn,
    output logic refreshBusy
);
    import bds_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ROW, ST_CAS, ST_CASPRE, ST_HOLD, ST_PRECH, ST_REFCAS, ST_REFRAS
    } bds_state_t;

    bds_state_t state;
    bds_state_t next_state;
    logic [CNT_W-1:0] cnt;
    bds_req_t cur;
    logic inPage;
    logic refreshDue;
    logic refreshStart;
    logic lastCyc;
    logic pageTake;
    logic sampleNow;
    logic sampleStrobe;
    bds_pins_t next_pins;

    // final count value of each timed state
    function automatic logic [CNT_W-1:0] stateLast(input bds_state_t s, input logic wr, input logic pg);
        int len;
        case (s)
            ST_ADDR: len = ASR_CYC;
            ST_ROW: len = RCD_CYC;
            ST_CAS: len = pg ? CAC_CYC : (wr ? WCAS_CYC : RCAS_CYC);
            ST_CASPRE: len = CP_CYC;
            ST_HOLD: len = RHCP_CYC;
            ST_PRECH: len = RP_CYC;
            ST_REFCAS: len = CSR_CYC;
            ST_REFRAS: len = CHR_CYC;
            default: len = 1;
        endcase
        return CNT_W'(len - 1);
    endfunction

    assign lastCyc = (cnt == stateLast(state, cur.write, inPage));

    // another read on the open row continues in page mode; refresh closes the page
    assign pageTake = (state == ST_CAS) && lastCyc && !cur.write && pageEnable && reqValid
                      && !req.write && (req.row == cur.row) && !refreshDue;
    assign reqReady = ((state == ST_IDLE) && !refreshDue) || pageTake;
    assign refreshStart = (state == ST_REFCAS) && lastCyc;
    assign sampleNow = (state == ST_CAS) && lastCyc && !cur.write;
    assign refreshBusy = (state == ST_REFCAS) || (state == ST_REFRAS);

    // state transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (refreshDue) begin
                    next_state = ST_REFCAS;
                end else if (reqValid) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: if (lastCyc) next_state = ST_ROW;
            ST_ROW: if (lastCyc) next_state = ST_CAS;
            ST_CAS: if (lastCyc) next_state = pageTake ? ST_CASPRE : ST_HOLD;
            ST_CASPRE: if (lastCyc) next_state = ST_CAS;
            ST_HOLD: if (lastCyc) next_state = ST_PRECH;
            ST_PRECH: if (lastCyc) next_state = ST_IDLE;
            ST_REFCAS: if (lastCyc) next_state = ST_REFRAS;
            ST_REFRAS: if (lastCyc) next_state = ST_PRECH;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // cycle counter restarts on every state change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= '0;
        end else if (state != next_state || state == ST_IDLE) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // request latch: full request at start, new column on a page hit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur <= '0;
        end else if (reqValid && reqReady) begin
            cur <= req;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            inPage <= 1'b0;
        end else if (pageTake) begin
            inPage <= 1'b1;
        end else if (state == ST_IDLE) begin
            inPage <= 1'b0;
        end
    end

    // pin values per state; write keeps WE low and data driven from RAS fall to CAS rise
    always_comb begin
        next_pins = PINS_REST;
        next_pins.addr = ADDR_W'(cur.row);
        case (state)
            ST_ADDR: next_pins.addr = ADDR_W'(cur.row);
            ST_ROW: begin
                next_pins.rasN = 1'b0;
                next_pins.addr = (cnt < CNT_W'(RAH_CYC)) ? ADDR_W'(cur.row) : ADDR_W'(cur.col);
                next_pins.weN = !cur.write;
                next_pins.dqOe = cur.write;
                next_pins.dqOut = cur.wdata;
            end
            ST_CAS: begin
                next_pins.rasN = 1'b0;
                next_pins.casN = 1'b0;
                next_pins.addr = ADDR_W'(cur.col);
                next_pins.weN = !cur.write;
                next_pins.dqOe = cur.write;
                next_pins.dqOut = cur.wdata;
            end
            ST_CASPRE, ST_HOLD: begin
                next_pins.rasN = 1'b0;
                next_pins.addr = ADDR_W'(cur.col);
            end
            ST_REFCAS: next_pins.casN = 1'b0;
            ST_REFRAS: begin
                next_pins.rasN = 1'b0;
                next_pins.casN = 1'b0;
            end
            default: next_pins = next_pins;
        endcase
    end

    // every pin leaves a flip-flop; relative spacing is kept because all shift together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dramPins <= PINS_REST;
            sampleStrobe <= 1'b0;
        end else begin
            dramPins <= next_pins;
            sampleStrobe <= sampleNow;
        end
    end

    bds_refresh_timer u_refresh (
        .sys_clk(sys_clk),
        .rst(rst),
        .memory_config_bit3(memory_config_bit3),
        .refreshStart(refreshStart),
        .refreshDue(refreshDue)
    );

    bds_read_capture u_capture (
        .sys_clk(sys_clk),
        .rst(rst),
        .dqIn(dqIn),
        .sampleStrobe(sampleStrobe),
        .rdValid(rdValid),
        .rdData(rdData)
    );
endmodule
`default_nettype wire

// ==== verification/bds_dram_model.sv ====
// Purpose: behavioural page-mode DRAM facing the sequencer pins
// Assumes: strobes sampled on sys_clk, data driven two CAS-low cycles after CAS falls
// Notes: when not driving, the data lines toggle every cycle so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module bds_dram_model (
    input wire logic sys_clk,
    input wire bds_pkg::bds_pins_t pins,
    output logic [bds_pkg::DATA_W-1:0] dq
);
    import bds_pkg::*;
    logic [DATA_W-1:0] mem [logic [17:0]];
    logic [ROW_W-1:0] row;
    logic rasQ = 1'b1;
    logic casQ = 1'b1;
    int age = 0;
    initial dq = 8'h5A;
    // latch row on RAS fall, write on CAS fall, drive read data inside the access limits
    always @(posedge sys_clk) begin
        rasQ <= pins.rasN;
        casQ <= pins.casN;
        if (rasQ && !pins.rasN) row <= pins.addr;
        if (casQ && !pins.casN && !pins.rasN && !pins.weN) mem[{row, pins.addr}] = pins.dqOut;
        if (!pins.casN && !pins.rasN && pins.weN) begin
            if (age == 1) dq <= mem[{row, pins.addr}];
            else if (age == 0) dq <= ~dq;
            age <= age + 1;
        end else begin
            dq <= ~dq;
            age <= 0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/bds_sequencer_chk.sv ====
// Purpose: pin timing checks for the buffer DRAM sequencer
// Assumes: one clock, rst synchronous and active high
// Notes: counts are whole cycles; the allowance is not taken, so checks are strict
`timescale 1ns/1ps
`default_nettype none
module bds_sequencer_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic memory_config_bit3,
    input wire logic pageEnable,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire bds_pkg::bds_req_t req,
    input wire logic rdValid,
    input wire logic [bds_pkg::DATA_W-1:0] rdData,
    input wire bds_pkg::bds_pins_t dramPins,
    input wire logic [bds_pkg::DATA_W-1:0] dqIn,
    input wire logic refreshBusy
);
    import bds_pkg::*;
    bds_pins_t p;
    logic rasQ;
    logic [REF_W:0] gap;
    logic [3:0] rasAge;
    assign p = dramPins;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since the last refresh row strobe; a refresh is RAS falling with CAS low
    always_ff @(posedge sys_clk) begin
        rasQ <= p.rasN;
        if (rst || (rasQ && !p.rasN && !p.casN)) begin
            gap <= '0;
        end else begin
            gap <= gap + 1'b1;
        end
    end
    // cycles since the last row strobe fall; saturates so a long idle spell cannot wrap into a false short gap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rasAge <= 4'hF;
        end else if (rasQ && !p.rasN) begin
            rasAge <= 4'h0;
        end else if (rasAge != 4'hF) begin
            rasAge <= rasAge + 4'h1;
        end
    end
    a_cycle_min_len: assert property ($fell(p.rasN) |-> rasAge >= 4'h9)
        else $error("row strobes closer than ten cycles");
    a_page_col_gap: assert property ($fell(p.casN) |-> ##1 (!$fell(p.casN))[*3])
        else $error("column strobes closer than four cycles");
    a_ras_cas_delay: assert property ($fell(p.casN) && !p.rasN |-> !$past(p.rasN, 2))
        else $error("column strobe too soon after row strobe");
    a_row_addr_setup: assert property ($fell(p.rasN) && p.casN |-> p.addr == $past(p.addr, 3))
        else $error("row address not set up");
    a_ras_hold_page: assert property ($rose(p.casN) && !p.rasN |-> (!p.rasN)[*4])
        else $error("row strobe released too soon after column precharge");
    a_cas_ras_gap: assert property ($rose(p.casN) |-> (!$fell(p.rasN))[*3])
        else $error("row strobe too soon after column strobe release");
    a_write_low_len: assert property ($fell(p.weN) |-> (!p.weN)[*5] ##1 (!p.weN)[*5])
        else $error("write command shorter than ten cycles");
    a_write_cas_hold: assert property ($fell(p.casN) && !p.weN |-> (!p.weN)[*6])
        else $error("write command released too soon after column strobe");
    a_wdata_hold: assert property ($fell(p.casN) && !p.weN |-> (p.dqOe && $stable(p.dqOut))[*3])
        else $error("write data not held after column strobe");
    a_refresh_order: assert property ($fell(p.rasN) && !p.casN |-> !$past(p.casN, 2) ##0 (!p.casN)[*6])
        else $error("refresh strobe order or hold wrong");
    a_refresh_gap: assert property (gap < (memory_config_bit3 ? 11'h320 : 11'h190))
        else $error("refresh interval too long");
endmodule
bind bds_sequencer bds_sequencer_chk chk (.sys_clk(sys_clk), .rst(rst), .memory_config_bit3(memory_config_bit3),
    .pageEnable(pageEnable), .reqValid(reqValid), .reqReady(reqReady), .req(req), .rdValid(rdValid),
    .rdData(rdData), .dramPins(dramPins), .dqIn(dqIn), .refreshBusy(refreshBusy));
`default_nettype wire

// ==== verification/bds_sequencer_tb.sv ====
// Purpose: self-checking bench for the buffer DRAM sequencer
// Assumes: inputs change on the falling clock edge
// Notes: refresh may steal the bus at any time, so every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module bds_sequencer_tb;
    import bds_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic memory_config_bit3 = 1'b0;
    logic pageEnable = 1'b0;
    logic reqValid = 1'b0;
    bds_req_t req = '0;
    logic reqReady, rdValid, refreshBusy;
    logic [DATA_W-1:0] rdData, dqIn;
    bds_pins_t dramPins;
    logic [8:0] rows [4] = '{9'h000, 9'h1FF, 9'h0AA, 9'h155};
    int errors = 0;
    int num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    bds_sequencer uut (.sys_clk(sys_clk), .rst(rst), .memory_config_bit3(memory_config_bit3),
        .pageEnable(pageEnable), .reqValid(reqValid), .reqReady(reqReady), .req(req), .rdValid(rdValid),
        .rdData(rdData), .dramPins(dramPins), .dqIn(dqIn), .refreshBusy(refreshBusy));
    bds_dram_model dram (.sys_clk(sys_clk), .pins(dramPins), .dq(dqIn));
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // hold the request until it is taken at a rising edge
    task automatic send(input logic w, input logic [8:0] r, input logic [8:0] c, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        req = '{write: w, row: r, col: c, wdata: d};
        reqValid = 1'b1;
        for (n = 0; n < 100 && reqReady !== 1'b1; n++) @(negedge sys_clk);
        if (n == 100) begin
            errors++;
            results();
        end
        @(negedge sys_clk);
        reqValid = 1'b0;
    endtask
    task automatic expectRd(input logic [7:0] d, output time t);
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge sys_clk);
            if (rdValid === 1'b1) break;
        end
        if (n == 60) begin
            errors++;
            results();
        end
        t = $time;
        chk("rdData", rdData, d);
    endtask
    task automatic t_reset();
        chk("dramPins", dramPins, PINS_REST);
        chk("reqReady", reqReady, 1'b1);
        $display("test reset done");
    endtask
    // back-to-back writes to boundary and alternating-bit rows then reads back
    task automatic t_random();
        time t;
        for (int i = 0; i < 4; i++) send(1'b1, rows[i], ~rows[i], rows[i][7:0] ^ 8'h3C);
        for (int i = 0; i < 4; i++) begin
            send(1'b0, rows[i], ~rows[i], 8'h00);
            expectRd(rows[i][7:0] ^ 8'h3C, t);
        end
        $display("test random done");
    endtask
    // reads on one open row must come four cycles apart
    task automatic t_page();
        time t [3];
        for (int c = 1; c < 4; c++) send(1'b1, 9'h0A5, c, 8'h10 + c);
        pageEnable = 1'b1;
        fork
            for (int c = 1; c < 4; c++) send(1'b0, 9'h0A5, c, 8'h00);
            for (int c = 1; c < 4; c++) expectRd(8'h10 + c, t[c-1]);
        join
        chk("page gap 1", (t[1] - t[0]) / 10, 4);
        chk("page gap 2", (t[2] - t[1]) / 10, 4);
        pageEnable = 1'b0;
        $display("test page done");
    endtask
    // cycles until refreshBusy next rises from low
    task automatic waitBusy(output int n);
        for (n = 0; n < 1000 && refreshBusy === 1'b1; n++) @(negedge sys_clk);
        for (; n < 1000 && refreshBusy !== 1'b1; n++) @(negedge sys_clk);
        if (n >= 1000) begin
            errors++;
            results();
        end
    endtask
    task automatic t_refresh(input logic cfg);
        int n;
        memory_config_bit3 = cfg;
        waitBusy(n);
        waitBusy(n);
        chk("refresh gap max", n <= (cfg ? 800 : 400), 1'b1);
        chk("refresh gap long", n > 400, cfg);
        $display("test refresh done");
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_random();
        t_page();
        t_refresh(1'b0);
        t_refresh(1'b1);
        results();
    end
endmodule
`default_nettype wire
